// file: rtl/ohd_pkg.sv
// Package: header layout, flag codes and decode types for the OTP header decoder
package ohd_pkg;

  localparam int OTP_WORDS = 8192;
  localparam int ADDR_W = 13;
  localparam int HDR_WORDS = 64;
  localparam logic [12:0] HDR_BASE_IDX = 13'h1fc0;

  // Header byte offsets within the OTP
  localparam logic [15:0] OFF_APP_FLAG1 = 16'h7f00;
  localparam logic [15:0] OFF_APP_FLAG2 = 16'h7f04;
  localparam logic [15:0] OFF_IQ_TRIM = 16'h7f08;
  localparam logic [15:0] OFF_TRIM_CRC = 16'h7f0c;
  localparam logic [15:0] OFF_PKG_FLAG = 16'h7f70;
  localparam logic [15:0] OFF_SLEEP_FLAG = 16'h7f74;
  localparam logic [15:0] OFF_CAL_FLAGS = 16'h7f78;
  localparam logic [15:0] OFF_TRIM_LAST = 16'h7f7c;
  localparam logic [15:0] OFF_TRIM_FIRST = 16'h7f90;
  localparam logic [15:0] OFF_SIG_FIRST = 16'h7f94;
  localparam logic [15:0] OFF_SIG_LAST = 16'h7fcc;
  localparam logic [15:0] OFF_SIG_SEL = 16'h7fd0;
  localparam logic [15:0] OFF_DEV_ADDR = 16'h7fd4;
  localparam logic [15:0] OFF_DMA_LEN = 16'h7ff8;
  localparam logic [15:0] OFF_RESERVED = 16'h7ff4;
  localparam logic [15:0] OFF_DBG_FLAG = 16'h7ffc;

  localparam int TRIM_COUNT = 6;
  localparam int SIG_WORDS = 15;

  // Replicated byte codes and magic values
  localparam logic [31:0] CODE_00 = 32'h0000_0000;
  localparam logic [31:0] CODE_AA = 32'haaaa_aaaa;
  localparam logic [31:0] CODE_55 = 32'h5555_5555;
  localparam logic [31:0] CODE_FF = 32'hffff_ffff;
  localparam logic [31:0] CODE_99 = 32'h9999_9999;
  localparam logic [31:0] APP_MAGIC1 = 32'h1234_a5a5;
  localparam logic [31:0] APP_MAGIC2 = 32'ha5a5_1234;
  localparam logic [15:0] CAL_DONE_MAGIC = 16'ha5a5;

  // Calibration flag field positions
  localparam int CAL_MARK_LSB = 16;
  localparam int CAL_VALID_LSB = 0;

  // Trim slot order, by descending address
  localparam int TRIM_VCO = 0;
  localparam int TRIM_FAST_XTAL = 1;
  localparam int TRIM_FAST_RC = 2;
  localparam int TRIM_BANDGAP = 3;
  localparam int TRIM_RF_PIN_CAP = 4;
  localparam int TRIM_LNA = 5;

  typedef enum logic [1:0] {OHD_SIG_NONE, OHD_SIG_MD5, OHD_SIG_SHA1, OHD_SIG_CRC32} ohd_sig_t;
  typedef enum logic [1:0] {OHD_PKG_CSP34, OHD_PKG_QFN40, OHD_PKG_QFN48, OHD_PKG_BARE_DIE} ohd_pkg_code_t;

endpackage

// file: rtl/ohd_word_capture.sv
// Module: word-index matched capture register for one header word
`timescale 1ns/1ps
module ohd_word_capture #(
  parameter logic [12:0] INDEX = 13'h0000
) (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic valid_in,
  input wire logic [12:0] index_in,
  input wire logic [31:0] data_in,
  output logic [31:0] word_out
);

  logic [31:0] word_reg;
  logic [31:0] word_next;
  wire logic hit = valid_in && (index_in == INDEX);

  assign word_next = hit ? data_in : word_reg;
  assign word_out = word_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      word_reg <= 32'h0000_0000;
    else
      word_reg <= word_next;
  end

endmodule

// file: rtl/ohd_header_decoder.sv
// Module: OTP header reader and decoder that presents boot configuration to the chip
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ps
// What this block does
// - Top header word maps debug port on pins (0x00) or leaves it unmapped (0xAA).
// - Blank all-zero debug flag keeps the debug port on its pins.
// - Length word gives count of 32-bit words mirrored into SRAM.
// - Device address is a six-byte string, first byte at lowest address.
// - Selector decodes none, MD5, SHA-1 or CRC32 signature.
// - Fifteen signature words read, used only when an algorithm is selected.
// - Six trim words placed in slots by descending address, VCO first, LNA last.
// - Upper calibration half-word 0xA5A5 means calibration done; zero means none.
// - Low six calibration bits mark each trim word valid; apply only when set.
// - Sleep flag selects sleep crystal (0x00) or precise RC sleep oscillator (0xAA).
// - Package flag decodes to four package kinds.
// - Stored CRC over trim and calibration values is presented.
// - IQ trim word is loaded and passed to radio configuration.
// - Normal mode only when both application flag words hold their magic values.
// - Byte codes are compared as full words replicated in all four bytes.
// - Customer-specific and reserved words are not interpreted.
// - Header is the last 64 words of an 8K-word OTP.
module ohd_header_decoder (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  output logic [12:0] otp_addr_out,
  output logic otp_rd_out,
  input wire logic [31:0] otp_data_in,
  output logic done_out,
  output logic debug_on_pins_out,
  output logic [31:0] mirror_word_count_out,
  output logic [47:0] device_addr_out,
  output logic [1:0] sig_algo_out,
  output logic [479:0] signature_out,
  output logic [191:0] trim_words_out,
  output logic [5:0] trim_valid_out,
  output logic cal_done_out,
  output logic sleep_rc_select_out,
  output logic [1:0] package_out,
  output logic [31:0] trim_crc_out,
  output logic [31:0] iq_trim_out,
  output logic normal_mode_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Read sequencer: walks the header once

  typedef enum logic [1:0] {OHD_ST_READ, OHD_ST_DECODE, OHD_ST_DONE} ohd_state_t;

  function automatic logic [12:0] word_index(input logic [15:0] byte_off);
    word_index = byte_off[14:2];
  endfunction

  ohd_state_t state_reg;
  ohd_state_t state_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic rd_reg;
  logic [12:0] addr_reg;
  logic cap_valid_reg;
  logic [12:0] cap_index_reg;

  wire logic last_issue = (cnt_reg == 6'h3f);
  // OTP answers one cycle after the read strobe
  wire logic cap_valid = rd_reg;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      OHD_ST_READ:
      begin
        cnt_next = cnt_reg + 6'h01;
        if (last_issue)
          state_next = OHD_ST_DECODE;
      end
      OHD_ST_DECODE:
        if (!cap_valid_reg)
          state_next = OHD_ST_DONE;
      OHD_ST_DONE:
        state_next = OHD_ST_DONE;
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      state_reg <= OHD_ST_READ;
      cnt_reg <= 6'h00;
      rd_reg <= 1'b0;
      addr_reg <= 13'h0000;
      cap_valid_reg <= 1'b0;
      cap_index_reg <= 13'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      rd_reg <= (state_reg == OHD_ST_READ);
      addr_reg <= ohd_pkg::HDR_BASE_IDX + {7'h00, cnt_reg};
      cap_valid_reg <= cap_valid;
      cap_index_reg <= addr_reg;
    end
  end

  assign otp_addr_out = addr_reg;
  assign otp_rd_out = rd_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Header word capture

  logic [31:0] hdr_word [0:ohd_pkg::HDR_WORDS-1];
  // Data returns a cycle after the strobe, so match on the delayed index
  wire logic [12:0] cap_index = cap_index_reg;

  // Reserved and customer words are captured but nothing reads them
  genvar gi;
  generate
    for (gi = 0; gi < ohd_pkg::HDR_WORDS; gi++)
    begin : g_word
      ohd_word_capture #(
        .INDEX(13'(ohd_pkg::HDR_BASE_IDX + 13'(gi)))
      ) u_cap (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .valid_in(cap_valid_reg),
        .index_in(cap_index),
        .data_in(otp_data_in),
        .word_out(hdr_word[gi])
      );
    end
  endgenerate

  function automatic logic [5:0] hdr_slot(input logic [15:0] byte_off);
    logic [12:0] idx;
    idx = word_index(byte_off) - ohd_pkg::HDR_BASE_IDX;
    hdr_slot = idx[5:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Field decode

  wire logic [31:0] w_dbg = hdr_word[hdr_slot(ohd_pkg::OFF_DBG_FLAG)];
  wire logic [31:0] w_len = hdr_word[hdr_slot(ohd_pkg::OFF_DMA_LEN)];
  wire logic [31:0] w_addr_lo = hdr_word[hdr_slot(ohd_pkg::OFF_DEV_ADDR)];
  wire logic [31:0] w_addr_hi = hdr_word[hdr_slot(ohd_pkg::OFF_DEV_ADDR) + 6'h01];
  wire logic [31:0] w_sig_sel = hdr_word[hdr_slot(ohd_pkg::OFF_SIG_SEL)];
  wire logic [31:0] w_cal = hdr_word[hdr_slot(ohd_pkg::OFF_CAL_FLAGS)];
  wire logic [31:0] w_sleep = hdr_word[hdr_slot(ohd_pkg::OFF_SLEEP_FLAG)];
  wire logic [31:0] w_pkg = hdr_word[hdr_slot(ohd_pkg::OFF_PKG_FLAG)];
  wire logic [31:0] w_crc = hdr_word[hdr_slot(ohd_pkg::OFF_TRIM_CRC)];
  wire logic [31:0] w_iq = hdr_word[hdr_slot(ohd_pkg::OFF_IQ_TRIM)];
  wire logic [31:0] w_app1 = hdr_word[hdr_slot(ohd_pkg::OFF_APP_FLAG1)];
  wire logic [31:0] w_app2 = hdr_word[hdr_slot(ohd_pkg::OFF_APP_FLAG2)];

  // Only 0xAA disables; zero and any junk keep the port usable for recovery
  wire logic dbg_on_next = (w_dbg != ohd_pkg::CODE_AA);

  // Byte string: lowest address holds the first byte
  wire logic [63:0] addr_bytes = {w_addr_lo[7:0], w_addr_lo[15:8], w_addr_lo[23:16], w_addr_lo[31:24],
                                  w_addr_hi[7:0], w_addr_hi[15:8], w_addr_hi[23:16], w_addr_hi[31:24]};
  wire logic [47:0] dev_addr_next = addr_bytes[63:16];

  wire logic [1:0] sig_next =
    (w_sig_sel == ohd_pkg::CODE_AA) ? 2'(ohd_pkg::OHD_SIG_MD5) :
    (w_sig_sel == ohd_pkg::CODE_55) ? 2'(ohd_pkg::OHD_SIG_SHA1) :
    (w_sig_sel == ohd_pkg::CODE_FF) ? 2'(ohd_pkg::OHD_SIG_CRC32) :
    2'(ohd_pkg::OHD_SIG_NONE);

  logic [479:0] sig_words;
  logic [191:0] trim_words;
  genvar si;
  generate
    for (si = 0; si < ohd_pkg::SIG_WORDS; si++)
    begin : g_sig
      assign sig_words[si*32 +: 32] = hdr_word[hdr_slot(ohd_pkg::OFF_SIG_FIRST) + 6'(si)];
    end
    for (si = 0; si < ohd_pkg::TRIM_COUNT; si++)
    begin : g_trim
      // Slot 0 is the VCO at the highest trim address
      assign trim_words[si*32 +: 32] = hdr_word[hdr_slot(ohd_pkg::OFF_TRIM_FIRST) - 6'(si)];
    end
  endgenerate

  // Zeroed when no algorithm so consumers never see stale data
  wire logic [479:0] sig_next_words = (sig_next == 2'(ohd_pkg::OHD_SIG_NONE)) ? 480'h0 : sig_words;

  wire logic [15:0] cal_mark = w_cal[ohd_pkg::CAL_MARK_LSB +: 16];
  wire logic cal_done_next = (cal_mark == ohd_pkg::CAL_DONE_MAGIC);
  // Bit 5 is VCO, bit 0 LNA; remap to slot order
  wire logic [5:0] cal_bits = w_cal[ohd_pkg::CAL_VALID_LSB +: 6];
  wire logic [5:0] valid_next = {cal_bits[0], cal_bits[1], cal_bits[2], cal_bits[3], cal_bits[4], cal_bits[5]};

  logic [191:0] trim_gated;
  generate
    for (si = 0; si < ohd_pkg::TRIM_COUNT; si++)
    begin : g_gate
      assign trim_gated[si*32 +: 32] = valid_next[si] ? trim_words[si*32 +: 32] : 32'h0000_0000;
    end
  endgenerate

  wire logic sleep_rc_next = (w_sleep == ohd_pkg::CODE_AA);

  wire logic [1:0] pkg_next =
    (w_pkg == ohd_pkg::CODE_AA) ? 2'(ohd_pkg::OHD_PKG_QFN40) :
    (w_pkg == ohd_pkg::CODE_55) ? 2'(ohd_pkg::OHD_PKG_QFN48) :
    (w_pkg == ohd_pkg::CODE_99) ? 2'(ohd_pkg::OHD_PKG_BARE_DIE) :
    2'(ohd_pkg::OHD_PKG_CSP34);

  wire logic normal_next = (w_app1 == ohd_pkg::APP_MAGIC1) && (w_app2 == ohd_pkg::APP_MAGIC2);

  ////////////////////////////////////////////////////////////////////////////
  // Output registers, loaded once at the end of the read pass

  wire logic load = (state_reg == OHD_ST_DECODE) && !cap_valid_reg;

  logic done_reg;
  logic dbg_reg;
  logic [31:0] len_reg;
  logic [47:0] dev_addr_reg;
  logic [1:0] sig_reg;
  logic [479:0] sig_words_reg;
  logic [191:0] trim_reg;
  logic [5:0] valid_reg;
  logic cal_done_reg;
  logic sleep_rc_reg;
  logic [1:0] pkg_reg;
  logic [31:0] crc_reg;
  logic [31:0] iq_reg;
  logic normal_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      done_reg <= 1'b0;
    else if (load)
      done_reg <= 1'b1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      dbg_reg <= 1'b1;
    else if (load)
      dbg_reg <= dbg_on_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      len_reg <= 32'h0000_0000;
    else if (load)
      len_reg <= w_len;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      dev_addr_reg <= 48'h0;
    else if (load)
      dev_addr_reg <= dev_addr_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      sig_reg <= 2'h0;
    else if (load)
      sig_reg <= sig_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      sig_words_reg <= 480'h0;
    else if (load)
      sig_words_reg <= sig_next_words;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      trim_reg <= 192'h0;
    else if (load)
      trim_reg <= trim_gated;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      valid_reg <= 6'h00;
    else if (load)
      valid_reg <= valid_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      cal_done_reg <= 1'b0;
    else if (load)
      cal_done_reg <= cal_done_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      sleep_rc_reg <= 1'b0;
    else if (load)
      sleep_rc_reg <= sleep_rc_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      pkg_reg <= 2'h0;
    else if (load)
      pkg_reg <= pkg_next;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      crc_reg <= 32'h0000_0000;
    else if (load)
      crc_reg <= w_crc;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      iq_reg <= 32'h0000_0000;
    else if (load)
      iq_reg <= w_iq;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
      normal_reg <= 1'b0;
    else if (load)
      normal_reg <= normal_next;
  end

  assign done_out = done_reg;
  assign debug_on_pins_out = dbg_reg;
  assign mirror_word_count_out = len_reg;
  assign device_addr_out = dev_addr_reg;
  assign sig_algo_out = sig_reg;
  assign signature_out = sig_words_reg;
  assign trim_words_out = trim_reg;
  assign trim_valid_out = valid_reg;
  assign cal_done_out = cal_done_reg;
  assign sleep_rc_select_out = sleep_rc_reg;
  assign package_out = pkg_reg;
  assign trim_crc_out = crc_reg;
  assign iq_trim_out = iq_reg;
  assign normal_mode_out = normal_reg;

endmodule

// file: test/ohd_header_props.sv
// Checker: port-level properties of the OTP header decoder
`timescale 1ns/1ps
module ohd_header_props (
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [12:0] otp_addr_out,
  input wire logic otp_rd_out,
  input wire logic done_out,
  input wire logic debug_on_pins_out,
  input wire logic [47:0] device_addr_out,
  input wire logic [1:0] sig_algo_out,
  input wire logic [479:0] signature_out,
  input wire logic [191:0] trim_words_out,
  input wire logic [5:0] trim_valid_out,
  input wire logic cal_done_out,
  input wire logic normal_mode_out
);
  logic [6:0] rd_cnt_reg;
  logic [191:0] trim_mask;

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);

  // Length of the current read burst, cleared between bursts
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !otp_rd_out)
      rd_cnt_reg <= 7'h00;
    else
      rd_cnt_reg <= rd_cnt_reg + 7'h01;
  end

  assign trim_mask = {{32{trim_valid_out[5]}}, {32{trim_valid_out[4]}}, {32{trim_valid_out[3]}},
                      {32{trim_valid_out[2]}}, {32{trim_valid_out[1]}}, {32{trim_valid_out[0]}}};

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_burst_end;
    $fell(otp_rd_out);
  endsequence
  sequence s_decoded;
    ##[1:5] done_out;
  endsequence

  property p_rd_start;
    $rose(otp_rd_out) |-> otp_addr_out == 13'h1fc0;
  endproperty
  a_rd_start: assert property (p_rd_start) else $error("header read does not start at first header word");
  property p_addr_step;
    otp_rd_out && $past(otp_rd_out) |-> otp_addr_out == $past(otp_addr_out) + 13'h0001;
  endproperty
  a_addr_step: assert property (p_addr_step) else $error("read address did not step by one");
  property p_rd_len;
    s_burst_end |-> rd_cnt_reg == 7'h40;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read burst is not 64 words long");
  property p_done_follow;
    s_burst_end |-> s_decoded;
  endproperty
  a_done_follow: assert property (p_done_follow) else $error("done missing after the read burst");
  property p_single_pass;
    done_out |-> !otp_rd_out;
  endproperty
  a_single_pass: assert property (p_single_pass) else $error("memory read again after done");
  property p_hold;
    done_out |=> done_out && $stable(device_addr_out) && $stable(sig_algo_out) && $stable(trim_words_out)
      && $stable(normal_mode_out);
  endproperty
  a_hold: assert property (p_hold) else $error("decoded settings changed after done");
  property p_debug_default;
    !done_out |-> debug_on_pins_out;
  endproperty
  a_debug_default: assert property (p_debug_default) else $error("debug port unmapped before decode");
  property p_sig_gate;
    sig_algo_out == 2'h0 |-> signature_out == '0;
  endproperty
  a_sig_gate: assert property (p_sig_gate) else $error("signature shown with no algorithm");
  property p_trim_gate;
    (trim_words_out & ~trim_mask) == '0;
  endproperty
  a_trim_gate: assert property (p_trim_gate) else $error("invalid trim slot is not zero");
  property p_early;
    !done_out |-> !normal_mode_out && !cal_done_out;
  endproperty
  a_early: assert property (p_early) else $error("decoded flag raised before done");
endmodule

bind ohd_header_decoder ohd_header_props u_props (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .otp_addr_out(otp_addr_out), .otp_rd_out(otp_rd_out),
  .done_out(done_out), .debug_on_pins_out(debug_on_pins_out), .device_addr_out(device_addr_out),
  .sig_algo_out(sig_algo_out), .signature_out(signature_out), .trim_words_out(trim_words_out),
  .trim_valid_out(trim_valid_out), .cal_done_out(cal_done_out), .normal_mode_out(normal_mode_out));

// file: test/ohd_otp_model.sv
// Model: OTP array holding the 64-word header, answering one cycle after each read
`timescale 1ns/1ps
module ohd_otp_model (
  input wire logic clk_sys_in,
  input wire logic rd_in,
  input wire logic [12:0] addr_in,
  output logic [31:0] data_out
);
  logic [31:0] mem [0:63];
  logic [31:0] data_reg;

  assign data_out = data_reg;

  // Idle bus toggles so a late sample never sees stale data
  always_ff @(posedge clk_sys_in)
  begin
    if (rd_in && addr_in >= ohd_pkg::HDR_BASE_IDX)
      data_reg <= mem[addr_in[5:0]];
    else
      data_reg <= ~data_reg;
  end
endmodule

// file: test/tb_top.sv
// Testbench: boots the header decoder over several OTP images and checks the decoded settings
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    total_checks++; \
    if ((a) !== (b)) \
    begin \
      failures++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module tb_top;
  logic clk_sys_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [12:0] otp_addr_out;
  logic otp_rd_out, done_out, debug_on_pins_out, cal_done_out, sleep_rc_select_out, normal_mode_out;
  logic [31:0] otp_data_in, mirror_word_count_out, trim_crc_out, iq_trim_out;
  logic [47:0] device_addr_out;
  logic [1:0] sig_algo_out, package_out;
  logic [479:0] signature_out;
  logic [191:0] trim_words_out;
  logic [5:0] trim_valid_out;
  int failures = 0;
  int total_checks = 0;

  always #2 clk_sys_in = ~clk_sys_in;

  ohd_header_decoder DUT (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .otp_addr_out(otp_addr_out),
    .otp_rd_out(otp_rd_out), .otp_data_in(otp_data_in), .done_out(done_out),
    .debug_on_pins_out(debug_on_pins_out), .mirror_word_count_out(mirror_word_count_out),
    .device_addr_out(device_addr_out), .sig_algo_out(sig_algo_out), .signature_out(signature_out),
    .trim_words_out(trim_words_out), .trim_valid_out(trim_valid_out), .cal_done_out(cal_done_out),
    .sleep_rc_select_out(sleep_rc_select_out), .package_out(package_out), .trim_crc_out(trim_crc_out),
    .iq_trim_out(iq_trim_out), .normal_mode_out(normal_mode_out));
  ohd_otp_model otp (.clk_sys_in(clk_sys_in), .rd_in(otp_rd_out), .addr_in(otp_addr_out), .data_out(otp_data_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic set_w(input logic [15:0] off, input logic [31:0] val);
    otp.mem[(off - 16'h7f00) >> 2] = val;
  endtask

  function automatic logic [1:0] sig_of(input logic [31:0] w);
    case (w)
      ohd_pkg::CODE_AA: return 2'h1;
      ohd_pkg::CODE_55: return 2'h2;
      ohd_pkg::CODE_FF: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  function automatic logic [1:0] pkg_of(input logic [31:0] w);
    case (w)
      ohd_pkg::CODE_AA: return 2'h1;
      ohd_pkg::CODE_55: return 2'h2;
      ohd_pkg::CODE_99: return 2'h3;
      default: return 2'h0;
    endcase
  endfunction

  // Loads an image under reset, boots, then compares every setting
  task automatic run_case(input int n, input logic [31:0] dbg, sig, pkg, slp, cal, a1, a2);
    logic [479:0] exp_sig;
    logic [191:0] exp_trim;
    logic [5:0] exp_val;
    int i;
    rst_n_in <= 1'b0;
    for (i = 0; i < 64; i++)
      otp.mem[i] = 32'haaaa_aaaa;
    set_w(ohd_pkg::OFF_RESERVED, 32'h0000_0000);
    set_w(ohd_pkg::OFF_DBG_FLAG, dbg);
    set_w(ohd_pkg::OFF_DMA_LEN, 32'h0000_1230 + 32'(n));
    set_w(ohd_pkg::OFF_DEV_ADDR, 32'h4433_2211);
    set_w(ohd_pkg::OFF_DEV_ADDR + 16'h0004, 32'h8877_6655);
    set_w(ohd_pkg::OFF_SIG_SEL, sig);
    set_w(ohd_pkg::OFF_CAL_FLAGS, cal);
    set_w(ohd_pkg::OFF_SLEEP_FLAG, slp);
    set_w(ohd_pkg::OFF_PKG_FLAG, pkg);
    set_w(ohd_pkg::OFF_TRIM_CRC, 32'hc0c0_1111);
    set_w(ohd_pkg::OFF_IQ_TRIM, 32'h1a1a_2222);
    set_w(ohd_pkg::OFF_APP_FLAG1, a1);
    set_w(ohd_pkg::OFF_APP_FLAG2, a2);
    for (i = 0; i < 15; i++)
    begin
      set_w(ohd_pkg::OFF_SIG_FIRST + 16'(4 * i), 32'h5100_0000 + 32'(i));
      exp_sig[32 * i +: 32] = (sig_of(sig) != 2'h0) ? 32'h5100_0000 + 32'(i) : 32'h0000_0000;
    end
    for (i = 0; i < 6; i++)
    begin
      set_w(ohd_pkg::OFF_TRIM_FIRST - 16'(4 * i), 32'h7100_0000 + 32'(i));
      exp_val[i] = cal[5 - i];
      exp_trim[32 * i +: 32] = exp_val[i] ? 32'h7100_0000 + 32'(i) : 32'h0000_0000;
    end
    repeat (2) @(posedge clk_sys_in);
    `CHK(done_out, 1'b0)
    `CHK(debug_on_pins_out, 1'b1)
    `CHK(otp_rd_out, 1'b0)
    rst_n_in <= 1'b1;
    for (i = 0; i < 200 && done_out !== 1'b1; i++)
      @(posedge clk_sys_in);
    repeat (2) @(posedge clk_sys_in);
    `CHK(done_out, 1'b1)
    `CHK(debug_on_pins_out, dbg !== ohd_pkg::CODE_AA)
    `CHK(mirror_word_count_out, 32'h0000_1230 + 32'(n))
    `CHK(device_addr_out, 48'h1122_3344_5566)
    `CHK(sig_algo_out, sig_of(sig))
    `CHK(signature_out, exp_sig)
    `CHK(trim_valid_out, exp_val)
    `CHK(trim_words_out, exp_trim)
    `CHK(cal_done_out, cal[31:16] === ohd_pkg::CAL_DONE_MAGIC)
    `CHK(sleep_rc_select_out, slp === ohd_pkg::CODE_AA)
    `CHK(package_out, pkg_of(pkg))
    `CHK(trim_crc_out, 32'hc0c0_1111)
    `CHK(iq_trim_out, 32'h1a1a_2222)
    `CHK(normal_mode_out, a1 === ohd_pkg::APP_MAGIC1 && a2 === ohd_pkg::APP_MAGIC2)
    $display("case %0d finished", n);
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Blank part, fully programmed part, then every code and some half-replicated ones
  initial
  begin
    run_case(0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
    run_case(1, ohd_pkg::CODE_AA, ohd_pkg::CODE_AA, ohd_pkg::CODE_AA, ohd_pkg::CODE_AA, 32'ha5a5_002a,
      ohd_pkg::APP_MAGIC1, ohd_pkg::APP_MAGIC2);
    run_case(2, ohd_pkg::CODE_00, ohd_pkg::CODE_55, ohd_pkg::CODE_55, 32'haaaa_aa00, 32'ha5a5_0015,
      ohd_pkg::APP_MAGIC1, 32'h0);
    run_case(3, 32'h0000_00aa, ohd_pkg::CODE_FF, ohd_pkg::CODE_99, ohd_pkg::CODE_00, 32'h0000_003f,
      ohd_pkg::APP_MAGIC2, ohd_pkg::APP_MAGIC1);
    run_case(4, ohd_pkg::CODE_FF, 32'h0000_00aa, 32'h9999_0000, ohd_pkg::CODE_55, 32'ha5a4_ffc0,
      ohd_pkg::APP_MAGIC1, ohd_pkg::APP_MAGIC2);
    wrap_up();
  end

  // Five boots of about 80 cycles each fit well inside this span
  initial
  begin
    #20000;
    failures++;
    wrap_up();
  end
endmodule
